// File: drive_input_regs.svh
// Register offsets, field codes, reset values and timing figures of the
// multifunction input terminal controller.
// Assumes a 5-bit register address and 16-bit register data.
`ifndef DRIVE_INPUT_REGS_SVH
`define DRIVE_INPUT_REGS_SVH
// ****************************************
// Register offsets
// ****************************************
`define A_FSEL_BASE 5'h00
`define A_NC_SEL 5'h08
`define A_INCH_FREQ 5'h09
`define A_INCH_STOP 5'h0A
`define A_START_FREQ 5'h0B
`define A_DCB_FORCE 5'h0C
`define A_DCB_WAIT 5'h0D
`define A_DCB_TIME 5'h0E
`define A_RAMP_CFG 5'h0F
`define A_ACC2_FREQ 5'h10
`define A_DEC2_FREQ 5'h11
`define A_ACC3_FREQ 5'h12
`define A_DEC3_FREQ 5'h13
`define A_STATUS 5'h14
// ****************************************
// Terminal function codes
// ****************************************
`define FN_REV 6'h01
`define FN_INCH 6'h06
`define FN_DCB 6'h07
`define FN_SECOND_SETUP_SELECT 6'h08
`define FN_RAMP2 6'h09
`define FN_RAMP3 6'h0A
// ****************************************
// Field codes and reset values
// ****************************************
`define STOP_COAST 2'h0
`define STOP_DECEL 2'h1
`define STOP_BRAKE 2'h2
`define CFG_M2_BIT 0
`define CFG_M3_BIT 1
`define FSEL_RST {6'h01, 6'h02, 6'h03, 6'h09, 6'h0B, 6'h06, 6'h10, 6'h11}
`define INCH_FREQ_RST 16'h0000
`define INCH_FREQ_MAX 16'h03E8
`define START_FREQ_RST 16'h0032
`define INCH_STOP_RST 2'h0
// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS 100
`define DCB_UNIT_NS 100000000
`define FILT_CYCLES_DEF 4
`endif

// File: drive_input_pkg.sv
// Types shared by the terminal controller and its two helper modules.
// Assumes nothing beyond a SystemVerilog compiler.
package drive_input_pkg;
  // Inching sequence, Gray along idle -> run -> hold
  typedef enum logic [1:0] {JOG_IDLE = 2'b00, JOG_RUN = 2'b01, JOG_HOLD = 2'b11} jog_state_e;
  // Braking sequence, Gray along idle -> wait -> brake
  typedef enum logic [1:0] {BRK_IDLE = 2'b00, BRK_WAIT = 2'b01, BRK_ON = 2'b11} brk_state_e;
  // State of one terminal conditioner
  typedef struct packed {
    logic [1:0] sync;
    logic [3:0] cnt;
    logic stable;
  } filt_s;
  // State of the braking sequencer
  typedef struct packed {
    brk_state_e st;
    logic timed;
    logic [7:0] cnt;
  } brk_s;
  // State of the main controller
  typedef struct packed {
    jog_state_e jog;
    logic [1:0] stop_held;
    logic run_q;
    logic [7:0][5:0] fsel;
    logic [8:0] nc;
    logic [15:0] inch_f;
    logic [15:0] start_f;
    logic [1:0] inch_stop;
    logic [7:0] dcb_force;
    logic [7:0] dcb_wait;
    logic [7:0] dcb_time;
    logic m2;
    logic m3;
    logic [15:0] acc2;
    logic [15:0] dec2;
    logic [15:0] acc3;
    logic [15:0] dec3;
    logic [15:0] rdata;
    logic [15:0] freq_cmd;
    logic [19:0] tick_cnt;
    logic tick;
    logic second_setup_select;
    logic [1:0] stage;
  } ctl_s;
endpackage

// File: term_filter.sv
// One terminal conditioner: two-stage synchroniser, stability filter and
// contact-type inversion.
// Assumes the pin is high while its contact is closed.
`timescale 1ns/1ps
`include "drive_input_regs.svh"
module term_filter
  import drive_input_pkg::*;
#(
  parameter int FILT_CYCLES = `FILT_CYCLES_DEF
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic pin_i,
  input wire logic nc_i,
  output logic active_o
);
  filt_s c; // Registered state
  filt_s n; // Next state

  // ****************************************
  // Next state
  // ****************************************
  // Only sync[1] feeds the filter; sync[0] may be metastable
  always_comb begin
    n = c;
    n.sync = {c.sync[0], pin_i};
    if (c.sync[1] == c.stable) begin
      n.cnt = 4'h0;
    end else if (c.cnt == 4'(FILT_CYCLES - 1)) begin
      // Held long enough: accept the new level
      n.stable = c.sync[1];
      n.cnt = 4'h0;
    end else begin
      n.cnt = 4'(c.cnt + 4'h1);
    end
  end

  // Register with freeze on clock enable
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      c <= '0;
    end else if (ce_i) begin
      c <= n;
    end
  end

  // Closed is active for normally open, open is active otherwise
  assign active_o = c.stable ^ nc_i;

  a_filt_hold: assert property (@(posedge mclk_i) disable iff (reset_i)
    ce_i && c.sync[1] == c.stable |=> $stable(c.stable))
    else $error("filtered level moved without a differing sample");
endmodule

// File: dc_brake_seq.sv
// DC braking sequencer: optional coast wait with output cut, then braking,
// either held by a terminal or timed from a start pulse.
// Assumes tick_i is a one-cycle pulse every 0.1 s on the same clock.
`timescale 1ns/1ps
module dc_brake_seq
  import drive_input_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic tick_i,
  input wire logic hold_i,
  input wire logic start_i,
  input wire logic [7:0] wait_i,
  input wire logic [7:0] time_i,
  output logic cut_o,
  output logic brake_o
);
  brk_s c; // Registered state
  brk_s n; // Next state
  logic [7:0] cnt_inc; // Count plus one tick

  assign cnt_inc = 8'(c.cnt + 8'h01);

  // ****************************************
  // Sequence
  // ****************************************
  always_comb begin
    n = c;
    unique case (c.st)
      BRK_IDLE: begin
        if (hold_i || start_i) begin
          // Terminal hold wins over a timed start in the same cycle
          n.timed = !hold_i;
          n.cnt = 8'h00;
          n.st = (wait_i == 8'h00) ? BRK_ON : BRK_WAIT;
        end
      end
      BRK_WAIT: begin
        if (!c.timed && !hold_i) begin
          n.st = BRK_IDLE;
        end else if (tick_i) begin
          n.cnt = cnt_inc;
          if (cnt_inc >= wait_i) begin
            n.st = BRK_ON;
            n.cnt = 8'h00;
          end
        end
      end
      BRK_ON: begin
        if (!c.timed && !hold_i) begin
          n.st = BRK_IDLE;
        end else if (c.timed && tick_i) begin
          n.cnt = cnt_inc;
          if (cnt_inc >= time_i) begin
            n.st = BRK_IDLE;
          end
        end
      end
      default: begin
        n.st = BRK_IDLE;
      end
    endcase
  end

  // Register with freeze on clock enable
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      c <= '0;
    end else if (ce_i) begin
      c <= n;
    end
  end

  // Output stays cut while the motor coasts through the wait
  assign cut_o = (c.st == BRK_WAIT);
  assign brake_o = (c.st == BRK_ON);

  a_wait_cut: assert property (@(posedge mclk_i) disable iff (reset_i)
    ce_i && c.st == BRK_IDLE && hold_i && wait_i != 8'h00 |=> cut_o && !brake_o)
    else $error("braking began before the wait period");
  a_hold_brake: assert property (@(posedge mclk_i) disable iff (reset_i)
    ce_i && c.st == BRK_IDLE && hold_i && wait_i == 8'h00 |=> brake_o)
    else $error("terminal braking did not start");
endmodule

// File: drive_input_function_control.sv
// Multifunction input terminal controller: inching run, terminal DC braking,
// second parameter set and second/third ramp stage selection.
// Assumes a same-clock ramp generator supplies output frequency and direction.
//
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "drive_input_regs.svh"
// Contract
// - inching needs inching terminal and terminal run
// - inching frequency 0.00 to 10.00 Hz, reset zero
// - no inching at start frequency or zero
// - inching end: coast, decelerate or DC brake
// - inching frequency applied directly, no ramp
// - function 06 gives inching, third terminal default
// - function 7 terminal switches DC braking directly
// - braking strength from DC braking force
// - nonzero wait: cut output, then brake
// - function 8 selects second parameter set
// - second set covers all motor parameters
// - function 09 selects second ramp times
// - second-ramp terminal honoured only with method 0
// - method 1 switches second ramp at frequencies
// - function 10 selects third ramp times
// - third terminal method 0, automatic method 1
// - contact type sets active level
module drive_input_function_control
  import drive_input_pkg::*;
#(
  parameter int TICK_CYCLES = `DCB_UNIT_NS / `CLK_PERIOD_NS,
  parameter int FILT_CYCLES = `FILT_CYCLES_DEF
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic [7:0] term_pin_i,
  input wire logic forward_run_input_i,
  input wire logic [4:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic [15:0] out_freq_i,
  input wire logic decelerating_i,
  output logic inching_active_o,
  output logic no_ramp_o,
  output logic [15:0] freq_cmd_o,
  output logic output_cut_o,
  output logic ramp_down_stop_o,
  output logic dc_brake_o,
  output logic [7:0] dc_brake_force_o,
  output logic setup2_o,
  output logic [1:0] ramp_stage_o
);
  // ****************************************
  // Declarations
  // ****************************************
  ctl_s c; // Registered state
  ctl_s n; // Next state
  logic [8:0] act; // Conditioned terminals, bit 8 is forward run
  logic inch_term; // Inching terminal active
  logic brake_term; // External braking terminal active
  logic second_setup_select_term; // Second setup terminal active
  logic ramp2_term; // Second ramp terminal active
  logic ramp3_term; // Third ramp terminal active
  logic rev_term; // Reverse run terminal active
  logic run_cmd; // Net run command
  logic run_rise; // First cycle of a run command
  logic inch_valid; // Inching frequency usable
  logic inch_end; // Inching run must stop now
  logic brk_start; // Timed braking at inching stop
  logic brk_cut; // Braking sequencer cuts output
  logic brk_on; // Braking sequencer brakes
  logic stage2; // Second ramp wanted
  logic stage3; // Third ramp wanted

  // ****************************************
  // Terminal conditioning
  // ****************************************
  // One conditioner per pin, each with its own contact type
  for (genvar k = 0; k < 9; k++) begin : g_term
    term_filter #(
      .FILT_CYCLES(FILT_CYCLES)
    ) u_filt (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .ce_i(ce_i),
      .pin_i((k == 8) ? forward_run_input_i : term_pin_i[k % 8]),
      .nc_i(c.nc[k]),
      .active_o(act[k])
    );
  end

  // Any active terminal carrying the given function code
  function automatic logic fn_hit(input logic [7:0][5:0] sel, input logic [7:0] a,
                                  input logic [5:0] code);
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < 8; k++) begin
      if (a[k] && sel[k] == code) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  assign inch_term = fn_hit(c.fsel, act[7:0], `FN_INCH);
  assign brake_term = fn_hit(c.fsel, act[7:0], `FN_DCB);
  assign second_setup_select_term = fn_hit(c.fsel, act[7:0], `FN_SECOND_SETUP_SELECT);
  assign ramp2_term = fn_hit(c.fsel, act[7:0], `FN_RAMP2);
  assign ramp3_term = fn_hit(c.fsel, act[7:0], `FN_RAMP3);
  assign rev_term = fn_hit(c.fsel, act[7:0], `FN_REV);

  // Forward and reverse together count as a stop
  assign run_cmd = act[8] ^ rev_term;
  assign run_rise = run_cmd && !c.run_q;
  assign inch_valid = (c.inch_f != 16'h0000) && (c.inch_f != c.start_f);
  assign inch_end = !run_cmd || !inch_term || !inch_valid;
  assign brk_start = (c.jog == JOG_RUN) && inch_end && (c.inch_stop == `STOP_BRAKE) && ce_i;

  // ****************************************
  // Ramp stage selection
  // ****************************************
  // Automatic changeover compares against the frequency for the present direction
  assign stage2 = c.m2 ? (decelerating_i ? out_freq_i >= c.dec2 : out_freq_i >= c.acc2)
                       : ramp2_term;
  assign stage3 = c.m3 ? (decelerating_i ? out_freq_i >= c.dec3 : out_freq_i >= c.acc3)
                       : ramp3_term;

  // ****************************************
  // Braking sequencer
  // ****************************************
  dc_brake_seq u_brake (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .tick_i(c.tick),
    .hold_i(brake_term),
    .start_i(brk_start),
    .wait_i(c.dcb_wait),
    .time_i(c.dcb_time),
    .cut_o(brk_cut),
    .brake_o(brk_on)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    n = c;
    n.run_q = run_cmd;
    // 0.1 s time base for the braking periods
    n.tick = (c.tick_cnt == 20'(TICK_CYCLES - 1));
    n.tick_cnt = n.tick ? 20'h0_0000 : 20'(c.tick_cnt + 20'h0_0001);
    // Register writes
    if (wr_i) begin
      if (addr_i < `A_NC_SEL) begin
        n.fsel[addr_i[2:0]] = wdata_i[5:0];
      end
      unique case (addr_i)
        `A_NC_SEL: n.nc = wdata_i[8:0];
        // Out-of-range inching frequency saturates at the ceiling
        `A_INCH_FREQ: n.inch_f = (wdata_i > `INCH_FREQ_MAX) ? `INCH_FREQ_MAX : wdata_i;
        `A_INCH_STOP: n.inch_stop = (wdata_i[1:0] == 2'h3) ? c.inch_stop : wdata_i[1:0];
        `A_START_FREQ: n.start_f = wdata_i;
        `A_DCB_FORCE: n.dcb_force = wdata_i[7:0];
        `A_DCB_WAIT: n.dcb_wait = wdata_i[7:0];
        `A_DCB_TIME: n.dcb_time = wdata_i[7:0];
        `A_RAMP_CFG: begin
          n.m2 = wdata_i[`CFG_M2_BIT];
          n.m3 = wdata_i[`CFG_M3_BIT];
        end
        `A_ACC2_FREQ: n.acc2 = wdata_i;
        `A_DEC2_FREQ: n.dec2 = wdata_i;
        `A_ACC3_FREQ: n.acc3 = wdata_i;
        `A_DEC3_FREQ: n.dec3 = wdata_i;
        default: begin
          // Function selects, status and holes take no write here
        end
      endcase
    end
    // Register reads, data stand one cycle after the strobe only
    n.rdata = 16'h0000;
    if (rd_i) begin
      if (addr_i < `A_NC_SEL) begin
        n.rdata = {10'h000, c.fsel[addr_i[2:0]]};
      end
      unique case (addr_i)
        `A_NC_SEL: n.rdata = {7'h00, c.nc};
        `A_INCH_FREQ: n.rdata = c.inch_f;
        `A_INCH_STOP: n.rdata = {14'h0000, c.inch_stop};
        `A_START_FREQ: n.rdata = c.start_f;
        `A_DCB_FORCE: n.rdata = {8'h00, c.dcb_force};
        `A_DCB_WAIT: n.rdata = {8'h00, c.dcb_wait};
        `A_DCB_TIME: n.rdata = {8'h00, c.dcb_time};
        `A_RAMP_CFG: n.rdata = {14'h0000, c.m3, c.m2};
        `A_ACC2_FREQ: n.rdata = c.acc2;
        `A_DEC2_FREQ: n.rdata = c.dec2;
        `A_ACC3_FREQ: n.rdata = c.acc3;
        `A_DEC3_FREQ: n.rdata = c.dec3;
        `A_STATUS: n.rdata = {act[7:0], 1'b0, run_cmd, c.stage, c.second_setup_select, brk_on, output_cut_o,
                              inching_active_o};
        default: begin
          // Unmapped and select addresses keep the value above
        end
      endcase
    end
    // Inching sequence
    unique case (c.jog)
      JOG_IDLE: begin
        // Inching terminal must already be on when run rises
        if (run_rise && inch_term && inch_valid) begin
          n.jog = JOG_RUN;
        end
      end
      JOG_RUN: begin
        if (inch_end) begin
          n.jog = JOG_HOLD;
          n.stop_held = c.inch_stop;
        end
      end
      JOG_HOLD: begin
        // Coast or decelerating stop holds until the next run command
        if (run_rise) begin
          n.jog = (inch_term && inch_valid) ? JOG_RUN : JOG_IDLE;
        end
      end
      default: begin
        n.jog = JOG_IDLE;
      end
    endcase
    // Inching frequency goes straight out, the ramp is bypassed
    n.freq_cmd = (n.jog == JOG_RUN) ? c.inch_f : 16'h0000;
    // Parameter set follows the terminal; the user keeps it stopped
    n.second_setup_select = second_setup_select_term;
    // Third stage wins when both are asked for
    n.stage = stage3 ? 2'h2 : (stage2 ? 2'h1 : 2'h0);
  end

  // ****************************************
  // State register
  // ****************************************
  // Synchronous reset loads documented defaults; low enable freezes all
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      c <= '0;
      c.fsel <= `FSEL_RST;
      c.inch_f <= `INCH_FREQ_RST;
      c.start_f <= `START_FREQ_RST;
      c.inch_stop <= `INCH_STOP_RST;
    end else if (ce_i) begin
      c <= n;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign rdata_o = c.rdata;
  assign inching_active_o = (c.jog == JOG_RUN);
  assign no_ramp_o = (c.jog == JOG_RUN);
  assign freq_cmd_o = c.freq_cmd;
  assign output_cut_o = ((c.jog == JOG_HOLD) && (c.stop_held == `STOP_COAST)) || brk_cut;
  assign ramp_down_stop_o = (c.jog == JOG_HOLD) && (c.stop_held == `STOP_DECEL);
  assign dc_brake_o = brk_on;
  assign dc_brake_force_o = brk_on ? c.dcb_force : 8'h00;
  assign setup2_o = c.second_setup_select;
  assign ramp_stage_o = c.stage;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  a_inch_needs_term: assert property (ce_i && c.jog == JOG_IDLE && !(run_rise && inch_term)
    |=> !inching_active_o)
    else $error("inching began without terminal and run edge");
  a_inch_freq_max: assert property (c.inch_f <= `INCH_FREQ_MAX)
    else $error("inching frequency above ceiling");
  a_inch_invalid: assert property (ce_i && c.jog == JOG_RUN && !inch_valid |=> !inching_active_o)
    else $error("inching kept at invalid frequency");
  a_stop_coast: assert property (ce_i && c.jog == JOG_RUN && !run_cmd && c.inch_stop == `STOP_COAST
    |=> output_cut_o && !ramp_down_stop_o)
    else $error("coast stop not applied at inching end");
  a_stop_decel: assert property (ce_i && c.jog == JOG_RUN && !run_cmd && c.inch_stop == `STOP_DECEL
    |=> ramp_down_stop_o)
    else $error("decelerating stop not applied at inching end");
  a_inch_direct: assert property (ce_i && c.jog == JOG_IDLE && run_rise && inch_term && inch_valid
    |=> no_ramp_o && freq_cmd_o == $past(c.inch_f))
    else $error("inching frequency not applied directly");
  a_brake_force: assert property (dc_brake_o |-> dc_brake_force_o == c.dcb_force)
    else $error("braking force differs from setting");
  a_setup_follow: assert property (ce_i |=> setup2_o == $past(second_setup_select_term))
    else $error("parameter set does not follow terminal");
  a_stage3_prio: assert property (ce_i && !c.m3 && ramp3_term |=> ramp_stage_o == 2'h2)
    else $error("third ramp stage lost priority");
  a_stage2_term: assert property (ce_i && !c.m2 && !c.m3 && ramp2_term && !ramp3_term
    |=> ramp_stage_o == 2'h1)
    else $error("second ramp terminal ignored");
  a_stage2_auto: assert property (ce_i && c.m2 && !c.m3 && !ramp3_term && !decelerating_i
    && out_freq_i < c.acc2 |=> ramp_stage_o == 2'h0)
    else $error("second ramp chosen below changeover");

  c_inch_run: cover property (c.jog == JOG_IDLE ##1 c.jog == JOG_RUN ##[1:50] c.jog == JOG_HOLD);
  c_brake: cover property (brk_cut ##[1:300] dc_brake_o);
  c_stage3: cover property (ramp_stage_o == 2'h1 ##1 ramp_stage_o == 2'h2);
endmodule

// File: contact_model.sv
// Behavioural model of the relay contacts or controller outputs on the terminals.
// Assumes a pin is high while its contact is closed and changes just after mclk_i rises.
`timescale 1ns/1ps
module contact_model #(
  parameter int GAP = 3
) (
  input wire logic mclk_i,
  input wire logic [7:0] close_i,
  input wire logic run_i,
  output logic [7:0] pin_o,
  output logic fwd_o
);
  // ****************************************
  // Run contact sequencing
  // ****************************************
  // Cycles for which the run request has been held
  logic [3:0] held_r = 4'h0;
  // Run contact trails the request, so an inching contact requested together with the run is closed first
  always_ff @(posedge mclk_i) begin
    if (!run_i) begin
      held_r <= 4'h0;
    end else if (held_r != 4'(GAP)) begin
      held_r <= held_r + 4'h1;
    end
  end
  // Terminal contacts follow the request directly
  assign pin_o = close_i;
  assign fwd_o = run_i && (held_r == 4'(GAP));
endmodule

// File: tb_top.sv
// Self-checking bench of the terminal controller, driven through its register port and contacts.
// Assumes the design package and header are compiled first; short tick and filter counts.
`timescale 1ns/1ps
module tb_top;
  import drive_input_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  localparam int TICK = 8;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] term_close = 8'h00;
  logic run_req = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [15:0] ofreq = 16'h0000;
  logic decel = 1'b0;
  logic ce = 1'b1;
  logic [7:0] pins;
  logic fwd;
  logic [15:0] rdata_o, freq_cmd_o;
  logic [7:0] dc_brake_force_o;
  logic [1:0] ramp_stage_o;
  logic inching_active_o, no_ramp_o, output_cut_o, ramp_down_stop_o, dc_brake_o, setup2_o;
  int n_fail = 0;
  int checked = 0;
  int i;
  logic [15:0] bad [2] = '{16'h0032, 16'h0000};
  // Free-running 10 MHz clock
  always #50 mclk_i = ~mclk_i;
  contact_model u_contacts (.mclk_i(mclk_i), .close_i(term_close), .run_i(run_req), .pin_o(pins), .fwd_o(fwd));
  drive_input_function_control #(.TICK_CYCLES(TICK), .FILT_CYCLES(2)) u_dut (
    .mclk_i(mclk_i), .reset_i(reset_i), .ce_i(ce), .term_pin_i(pins), .forward_run_input_i(fwd),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata_o),
    .out_freq_i(ofreq), .decelerating_i(decel), .inching_active_o(inching_active_o),
    .no_ramp_o(no_ramp_o), .freq_cmd_o(freq_cmd_o), .output_cut_o(output_cut_o),
    .ramp_down_stop_o(ramp_down_stop_o), .dc_brake_o(dc_brake_o),
    .dc_brake_force_o(dc_brake_force_o), .setup2_o(setup2_o), .ramp_stage_o(ramp_stage_o));
  // ****************************************
  // Tasks
  // ****************************************
  // Compare and count; report a mismatch at once
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Let outputs settle, then sample mid-cycle away from the edge
  task automatic settle(input int n);
    repeat (n) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge mclk_i);
    wr_s <= 1'b0;
  endtask
  // One-cycle read strobe; data stands only in the following cycle
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge mclk_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge mclk_i);
    rd_s <= 1'b0;
    @(negedge mclk_i);
    chk("rdata", exp, rdata_o);
  endtask
  // Contacts change, then wait out sync, filter and run sequencing
  task automatic contacts(input logic [7:0] t, input logic r);
    @(posedge mclk_i);
    term_close <= t;
    run_req <= r;
    settle(12);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge mclk_i);
    reset_i <= 1'b0;
    // Reset values, saturation, refused codes, unmapped place
    rd(5'h09, 16'h0000);
    rd(5'h0A, 16'h0000);
    rd(5'h02, 16'h0006);
    wr(5'h09, 16'h07D0);
    rd(5'h09, 16'h03E8);
    wr(5'h0A, 16'h0003);
    rd(5'h0A, 16'h0000);
    rd(5'h1F, 16'h0000);
    $display("test registers done");
    // Inching on the default third terminal, every stop method
    wr(5'h09, 16'h0064);
    wr(5'h0E, 16'h0003);
    wr(5'h0C, 16'h005A);
    for (int s = 0; s < 3; s++) begin
      wr(5'h0A, 16'(s));
      contacts(8'h04, 1'b0);
      contacts(8'h04, 1'b1);
      chk("jog_flags", 16'h0003, {14'h0, inching_active_o, no_ramp_o});
      chk("jog_freq", 16'h0064, freq_cmd_o);
      contacts(8'h04, 1'b0);
      chk("stop_act", {13'h0, s == 2, s == 1, s == 0}, {13'h0, dc_brake_o, ramp_down_stop_o, output_cut_o});
      chk("jog_force", (s == 2) ? 16'h005A : 16'h0000, {8'h00, dc_brake_force_o});
      settle(40);
    end
    // Invalid frequencies give no inching
    foreach (bad[k]) begin
      wr(5'h09, bad[k]);
      contacts(8'h04, 1'b0);
      contacts(8'h04, 1'b1);
      chk("jog_bad", 16'h0000, {freq_cmd_o[15:1], freq_cmd_o[0] | inching_active_o});
    end
    // Run before the inching contact is refused
    wr(5'h09, 16'h0064);
    contacts(8'h00, 1'b0);
    contacts(8'h00, 1'b1);
    contacts(8'h04, 1'b1);
    chk("jog_order", 16'h0000, {15'h0, inching_active_o});
    contacts(8'h00, 1'b0);
    $display("test inching done");
    // Terminal braking with a two-tick coast wait
    wr(5'h00, 16'h0007);
    wr(5'h0D, 16'h0002);
    @(posedge mclk_i);
    term_close <= 8'h01;
    for (i = 0; i < 20 && output_cut_o !== 1'b1; i++) @(negedge mclk_i);
    chk("brk_wait", 16'h0001, {14'h0, dc_brake_o, output_cut_o});
    if (i >= 20) finish_test();
    for (i = 0; i < 30 && dc_brake_o !== 1'b1; i++) @(negedge mclk_i);
    chk("wait_len", 16'h0001, {15'h0, i >= TICK - 1 && i <= 2 * TICK + 2});
    if (i >= 30) finish_test();
    chk("brk_on", 16'h015A, {7'h0, dc_brake_o, dc_brake_force_o});
    contacts(8'h00, 1'b0);
    chk("brk_off", 16'h0000, {14'h0, dc_brake_o, output_cut_o});
    // No wait: braking follows the terminal with no coast period
    wr(5'h0D, 16'h0000);
    contacts(8'h01, 1'b0);
    chk("brk_nowait", 16'h0002, {14'h0, dc_brake_o, output_cut_o});
    contacts(8'h00, 1'b0);
    $display("test braking done");
    // Second set, stopped, both contact types
    wr(5'h01, 16'h0008);
    contacts(8'h02, 1'b0);
    chk("second_setup_select_on", 16'h0001, {15'h0, setup2_o});
    wr(5'h08, 16'h0002);
    settle(8);
    chk("second_setup_select_nc_closed", 16'h0000, {15'h0, setup2_o});
    contacts(8'h00, 1'b0);
    chk("second_setup_select_nc_open", 16'h0001, {15'h0, setup2_o});
    wr(5'h08, 16'h0000);
    settle(8);
    chk("second_setup_select_off", 16'h0000, {15'h0, setup2_o});
    $display("test setup done");
    // Ramp stages by terminal, then automatic
    contacts(8'h10, 1'b0);
    chk("stage2_term", 16'h0001, {14'h0, ramp_stage_o});
    wr(5'h03, 16'h000A);
    contacts(8'h18, 1'b0);
    chk("stage_both", 16'h0002, {14'h0, ramp_stage_o});
    contacts(8'h00, 1'b0);
    chk("stage_off", 16'h0000, {14'h0, ramp_stage_o});
    wr(5'h10, 16'h1000);
    wr(5'h11, 16'h0800);
    wr(5'h12, 16'h2000);
    wr(5'h0F, 16'h0001);
    ofreq <= 16'h0800;
    contacts(8'h10, 1'b0);
    chk("stage_auto_lo", 16'h0000, {14'h0, ramp_stage_o});
    @(posedge mclk_i);
    decel <= 1'b1;
    settle(3);
    chk("stage_auto_dec", 16'h0001, {14'h0, ramp_stage_o});
    @(posedge mclk_i);
    decel <= 1'b0;
    ofreq <= 16'h1000;
    settle(3);
    chk("stage_auto_acc", 16'h0001, {14'h0, ramp_stage_o});
    wr(5'h0F, 16'h0003);
    ofreq <= 16'h2000;
    settle(3);
    chk("stage_auto3", 16'h0002, {14'h0, ramp_stage_o});
    // Low clock enable freezes the stage although the frequency drops
    @(posedge mclk_i);
    ce <= 1'b0;
    ofreq <= 16'h0000;
    settle(3);
    chk("ce_hold", 16'h0002, {14'h0, ramp_stage_o});
    @(posedge mclk_i);
    ce <= 1'b1;
    settle(3);
    chk("ce_run", 16'h0000, {14'h0, ramp_stage_o});
    $display("test ramps done");
    finish_test();
  end
endmodule
